// *** logic/spcd_defs.vh ***
// constants of the serial controller flag/status and clock divider block
// assumes inclusion by every design file of the block; definitions only
`ifndef SPCD_DEFS_VH
`define SPCD_DEFS_VH

// ----------------------------------------------------------------------
// register indices as printed, byte address is four times the index
// ----------------------------------------------------------------------
`define SPCD_IDX_CLOCK_DIVIDER   8'h9D
`define SPCD_IDX_CONTROL_STATUS  8'hF8
`define SPCD_IDX_IRQ_STATUS      8'hF9
`define SPCD_IDX_IRQ_MASK        8'hFA
`define SPCD_ADDR_WIDTH          12

// ----------------------------------------------------------------------
// control/status field positions
// ----------------------------------------------------------------------
`define SPCD_BIT_COMPLETE        7
`define SPCD_BIT_WRITE_COLLISION_FLAG            6
`define SPCD_BIT_MODE_FAULT_FLAG            5
`define SPCD_BIT_OVERRUN         4
`define SPCD_BIT_BUSY            3
`define SPCD_BIT_SLAVE_SELECTED_STATUS          2
`define SPCD_BIT_MASTER          1
`define SPCD_BIT_ENABLE          0

// ----------------------------------------------------------------------
// interrupt status and mask field positions
// ----------------------------------------------------------------------
`define SPCD_IRQ_COMPLETE        0
`define SPCD_IRQ_WRITE_COLLISION_FLAG            1
`define SPCD_IRQ_MODE_FAULT_FLAG            2
`define SPCD_IRQ_OVERRUN         3
`define SPCD_IRQ_WIDTH           4

// ----------------------------------------------------------------------
// reset values and bus answers
// ----------------------------------------------------------------------
`define SPCD_RST_CLOCK_DIVIDER   8'h00
`define SPCD_RST_CONTROL_STATUS  8'h00
`define SPCD_RST_IRQ             4'h0
`define SPCD_RESP_OKAY           2'h0
`define SPCD_RESP_SLVERR         2'h2

`endif

// *** logic/spcd_clkdiv.v ***
// serial clock divider: half period of divider value plus one system clocks
// assumes run is a level from the same clock domain; divider may change any time
`timescale 1ns/1ps
`include "spcd_defs.vh"

module spcd_clkdiv #(
   parameter DIV_WIDTH = 8
) (
   input  wire                 aclk,
   input  wire                 aresetn,
   input  wire                 run,
   input  wire [DIV_WIDTH-1:0] divider,
   output reg                  sck_q,
   output reg                  rise_q,
   output reg                  fall_q
);

   reg [DIV_WIDTH-1:0] cnt_q;
   wire                term;

   // a shrinking divider must not strand the counter above it
   assign term = (cnt_q >= divider);

   // ----------------------------------------------------------------------
   // half-period counter and clock toggle
   // ----------------------------------------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q  <= {DIV_WIDTH{1'b0}};
         sck_q  <= 1'b0;
         rise_q <= 1'b0;
         fall_q <= 1'b0;
      end else if (!run) begin
         // idle low so the first edge of a transfer is always a rise
         cnt_q  <= {DIV_WIDTH{1'b0}};
         sck_q  <= 1'b0;
         rise_q <= 1'b0;
         fall_q <= 1'b0;
      end else if (term) begin
         cnt_q  <= {DIV_WIDTH{1'b0}};
         sck_q  <= ~sck_q;
         rise_q <= ~sck_q;
         fall_q <= sck_q;
      end else begin
         cnt_q  <= cnt_q + {{(DIV_WIDTH-1){1'b0}}, 1'b1};
         rise_q <= 1'b0;
         fall_q <= 1'b0;
      end
   end

endmodule // spcd_clkdiv

// *** logic/spcd_top.v ***
// flag/status registers and master clock divider of a serial peripheral port
// assumes shift logic on aclk supplies done, busy, unread and collision levels;
// slave select arrives straight from a pin and is synchronised here
`timescale 1ns/1ps
`include "spcd_defs.vh"

// Operation
// - master mode with slave select sampled low sets the mode fault flag
// - a mode fault also raises the interrupt request
// - last bit in while receive data unread sets overrun and interrupts
// - mode fault and overrun stay set until software writes zero
// - slave selected status reads one while slave select is low
// - master clock is half system clock over divider value plus one
module spcd_top #(
   parameter DIV_WIDTH = 8
) (
   input  wire                        aclk,
   input  wire                        aresetn,
   input  wire [`SPCD_ADDR_WIDTH-1:0] s_axi_awaddr,
   input  wire [2:0]                  s_axi_awprot,
   input  wire                        s_axi_awvalid,
   output wire                        s_axi_awready,
   input  wire [31:0]                 s_axi_wdata,
   input  wire [3:0]                  s_axi_wstrb,
   input  wire                        s_axi_wvalid,
   output wire                        s_axi_wready,
   output reg  [1:0]                  s_axi_bresp,
   output reg                         s_axi_bvalid,
   input  wire                        s_axi_bready,
   input  wire [`SPCD_ADDR_WIDTH-1:0] s_axi_araddr,
   input  wire [2:0]                  s_axi_arprot,
   input  wire                        s_axi_arvalid,
   output wire                        s_axi_arready,
   output reg  [31:0]                 s_axi_rdata,
   output reg  [1:0]                  s_axi_rresp,
   output reg                         s_axi_rvalid,
   input  wire                        s_axi_rready,
   input  wire                        slave_select_n,
   input  wire                        xfer_last_bit,
   input  wire                        xfer_done,
   input  wire                        rx_unread,
   input  wire                        xfer_busy,
   input  wire                        write_collision,
   input  wire                        sck_run,
   output wire                        sck_out,
   output wire                        sck_oe,
   output wire                        sck_rise,
   output wire                        sck_fall,
   output wire                        master_mode_enable,
   output wire                        module_enable,
   output wire                        irq
);

   // ----------------------------------------------------------------------
   // byte addresses, four times the register index
   // ----------------------------------------------------------------------
   localparam [`SPCD_ADDR_WIDTH-1:0] ADDR_DIV  = {2'b00, `SPCD_IDX_CLOCK_DIVIDER, 2'b00};
   localparam [`SPCD_ADDR_WIDTH-1:0] ADDR_CTL  = {2'b00, `SPCD_IDX_CONTROL_STATUS, 2'b00};
   localparam [`SPCD_ADDR_WIDTH-1:0] ADDR_IST  = {2'b00, `SPCD_IDX_IRQ_STATUS, 2'b00};
   localparam [`SPCD_ADDR_WIDTH-1:0] ADDR_IMSK = {2'b00, `SPCD_IDX_IRQ_MASK, 2'b00};
   localparam [7:0]                  CTL_RST   = `SPCD_RST_CONTROL_STATUS;

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   reg [DIV_WIDTH-1:0]        divider_q;
   reg                        master_q;
   reg                        enable_q;
   reg                        complete_q;
   reg                        write_collision_flag_q;
   reg                        mode_fault_flag_q;
   reg                        overrun_q;
   reg [`SPCD_IRQ_WIDTH-1:0]  irq_status_q;
   reg [`SPCD_IRQ_WIDTH-1:0]  irq_mask_q;
   reg                        nss_meta_q;
   reg                        nss_sync_q;
   reg                        aw_have_q;
   reg                        w_have_q;
   reg [`SPCD_ADDR_WIDTH-1:0] aw_addr_q;
   reg [31:0]                 w_data_q;
   reg [3:0]                  w_strb_q;

   wire                       wr_fire;
   wire                       wr_lane0;
   wire                       wr_div;
   wire                       wr_ctl;
   wire                       wr_ist;
   wire                       wr_imsk;
   wire                       wr_hit;
   wire [7:0]                 wbyte;
   wire                       ev_mode_fault_flag;
   wire                       ev_overrun;
   wire [`SPCD_IRQ_WIDTH-1:0] ev_vec;
   wire [7:0]                 ctl_view;
   wire                       sck_q;

   // ----------------------------------------------------------------------
   // slave select synchroniser
   // ----------------------------------------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         // idle high so no false fault appears out of reset
         nss_meta_q <= 1'b1;
         nss_sync_q <= 1'b1;
      end else begin
         nss_meta_q <= slave_select_n;
         nss_sync_q <= nss_meta_q;
      end
   end

   // ----------------------------------------------------------------------
   // events
   // ----------------------------------------------------------------------
   // a fault is flagged even while the module is disabled
   assign ev_mode_fault_flag    = master_q & ~nss_sync_q;
   assign ev_overrun = xfer_last_bit & rx_unread;

   assign ev_vec[`SPCD_IRQ_COMPLETE] = xfer_done;
   assign ev_vec[`SPCD_IRQ_WRITE_COLLISION_FLAG]     = write_collision;
   assign ev_vec[`SPCD_IRQ_MODE_FAULT_FLAG]     = ev_mode_fault_flag;
   assign ev_vec[`SPCD_IRQ_OVERRUN]  = ev_overrun;

   // ----------------------------------------------------------------------
   // write channel: address and data taken in either order
   // ----------------------------------------------------------------------
   assign s_axi_awready = ~aw_have_q & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_have_q & ~s_axi_bvalid;
   assign wr_fire       = aw_have_q & w_have_q & ~s_axi_bvalid;
   assign wr_lane0      = wr_fire & w_strb_q[0];
   assign wbyte         = w_data_q[7:0];

   assign wr_div  = (aw_addr_q == ADDR_DIV);
   assign wr_ctl  = (aw_addr_q == ADDR_CTL);
   assign wr_ist  = (aw_addr_q == ADDR_IST);
   assign wr_imsk = (aw_addr_q == ADDR_IMSK);
   assign wr_hit  = wr_div | wr_ctl | wr_ist | wr_imsk;

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q    <= 1'b0;
         w_have_q     <= 1'b0;
         aw_addr_q    <= {`SPCD_ADDR_WIDTH{1'b0}};
         w_data_q     <= 32'h00000000;
         w_strb_q     <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `SPCD_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= {s_axi_awaddr[`SPCD_ADDR_WIDTH-1:2], 2'b00};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_have_q    <= 1'b0;
            w_have_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? `SPCD_RESP_OKAY : `SPCD_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------------
   // divider and control bits
   // ----------------------------------------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         divider_q <= `SPCD_RST_CLOCK_DIVIDER;
         master_q  <= CTL_RST[`SPCD_BIT_MASTER];
         enable_q  <= CTL_RST[`SPCD_BIT_ENABLE];
      end else begin
         if (wr_lane0 && wr_div) begin
            divider_q <= wbyte[DIV_WIDTH-1:0];
         end
         if (wr_lane0 && wr_ctl) begin
            master_q <= wbyte[`SPCD_BIT_MASTER];
            enable_q <= wbyte[`SPCD_BIT_ENABLE];
         end
      end
   end

   // ----------------------------------------------------------------------
   // sticky flags: writing zero clears, writing one keeps, a same-cycle
   // event wins over the clear so no fault can slip past software
   // ----------------------------------------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         complete_q <= 1'b0;
         write_collision_flag_q     <= 1'b0;
         mode_fault_flag_q     <= 1'b0;
         overrun_q  <= 1'b0;
      end else begin
         if (xfer_done) begin
            complete_q <= 1'b1;
         end else if (wr_lane0 && wr_ctl && !wbyte[`SPCD_BIT_COMPLETE]) begin
            complete_q <= 1'b0;
         end
         if (write_collision) begin
            write_collision_flag_q <= 1'b1;
         end else if (wr_lane0 && wr_ctl && !wbyte[`SPCD_BIT_WRITE_COLLISION_FLAG]) begin
            write_collision_flag_q <= 1'b0;
         end
         if (ev_mode_fault_flag) begin
            mode_fault_flag_q <= 1'b1;
         end else if (wr_lane0 && wr_ctl && !wbyte[`SPCD_BIT_MODE_FAULT_FLAG]) begin
            mode_fault_flag_q <= 1'b0;
         end
         if (ev_overrun) begin
            overrun_q <= 1'b1;
         end else if (wr_lane0 && wr_ctl && !wbyte[`SPCD_BIT_OVERRUN]) begin
            overrun_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------------
   // interrupt status (write one to clear) and mask
   // ----------------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < `SPCD_IRQ_WIDTH; gi = gi + 1) begin : g_irq
         always @(posedge aclk) begin
            if (!aresetn) begin
               irq_status_q[gi] <= 1'b0;
               irq_mask_q[gi]   <= 1'b0;
            end else begin
               if (ev_vec[gi]) begin
                  irq_status_q[gi] <= 1'b1;
               end else if (wr_lane0 && wr_ist && wbyte[gi]) begin
                  irq_status_q[gi] <= 1'b0;
               end
               if (wr_lane0 && wr_imsk) begin
                  irq_mask_q[gi] <= wbyte[gi];
               end
            end
         end
      end
   endgenerate

   // interrupt entry never touches the flags; only bus writes clear them
   assign irq = |(irq_status_q & irq_mask_q);

   // ----------------------------------------------------------------------
   // read channel
   // ----------------------------------------------------------------------
   assign s_axi_arready = ~s_axi_rvalid;

   assign ctl_view = {complete_q,
                      write_collision_flag_q,
                      mode_fault_flag_q,
                      overrun_q,
                      xfer_busy,
                      ~nss_sync_q,
                      master_q,
                      enable_q};

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= `SPCD_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= `SPCD_RESP_OKAY;
         if ({s_axi_araddr[`SPCD_ADDR_WIDTH-1:2], 2'b00} == ADDR_DIV) begin
            s_axi_rdata <= {{(32-DIV_WIDTH){1'b0}}, divider_q};
         end else if ({s_axi_araddr[`SPCD_ADDR_WIDTH-1:2], 2'b00} == ADDR_CTL) begin
            s_axi_rdata <= {24'h000000, ctl_view};
         end else if ({s_axi_araddr[`SPCD_ADDR_WIDTH-1:2], 2'b00} == ADDR_IST) begin
            s_axi_rdata <= {28'h0000000, irq_status_q};
         end else if ({s_axi_araddr[`SPCD_ADDR_WIDTH-1:2], 2'b00} == ADDR_IMSK) begin
            s_axi_rdata <= {28'h0000000, irq_mask_q};
         end else begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `SPCD_RESP_SLVERR;
         end
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // master serial clock
   // ----------------------------------------------------------------------
   spcd_clkdiv #(
      .DIV_WIDTH (DIV_WIDTH)
   ) u_clkdiv (
      .aclk    (aclk),
      .aresetn (aresetn),
      .run     (enable_q & master_q & sck_run),
      .divider (divider_q),
      .sck_q   (sck_q),
      .rise_q  (sck_rise),
      .fall_q  (sck_fall)
   );

   assign sck_out            = sck_q;
   assign sck_oe             = enable_q & master_q;
   assign master_mode_enable = master_q;
   assign module_enable      = enable_q;

endmodule // spcd_top

// *** dv/spcd_sva.sv ***
// checker for the serial port flag/status and clock divider block
// assumes it is bound to spcd_top and sees only its ports
`timescale 1ns/1ps
`include "spcd_defs.vh"

module spcd_sva (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        sck_run,
   input wire logic        sck_out,
   input wire logic        sck_oe,
   input wire logic        sck_rise,
   input wire logic        sck_fall,
   input wire logic        master_mode_enable,
   input wire logic        module_enable,
   input wire logic        irq
);
   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   logic [8:0] quiet_q;
   // a half period is at most 256 cycles, so a longer quiet spell means a stuck divider
   always @(posedge aclk)
      if (!aresetn || !(sck_oe && sck_run) || sck_rise || sck_fall) quiet_q <= 9'h000;
      else quiet_q <= quiet_q + 9'h001;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_sck_stop; !(sck_oe && sck_run) |=> !sck_out; endproperty
   a_sck_stop: assert property (p_sck_stop) else $error("serial clock runs while stopped");
   property p_sck_oe; sck_oe == (module_enable && master_mode_enable); endproperty
   a_sck_oe: assert property (p_sck_oe) else $error("clock drive enable wrong");
   property p_rise; sck_rise |-> $rose(sck_out); endproperty
   a_rise: assert property (p_rise) else $error("rise pulse without rising clock");
   property p_fall; sck_fall |-> $fell(sck_out); endproperty
   a_fall: assert property (p_fall) else $error("fall pulse without falling clock");
   property p_half; quiet_q <= 9'd257; endproperty
   a_half: assert property (p_half) else $error("serial clock half period too long");
   property p_irq_fall; $fell(irq) |-> $rose(s_axi_bvalid); endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("interrupt dropped without a write");
   property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
   a_bhold: assert property (p_bhold) else $error("write response not held");
   property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
   a_rhold: assert property (p_rhold) else $error("read data not held");
   property p_rlat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
   a_rlat: assert property (p_rlat) else $error("read answer late");

   c_rise: cover property (sck_rise);
   c_irq: cover property ($rose(irq));
   c_slverr: cover property (s_axi_bvalid && s_axi_bresp == `SPCD_RESP_SLVERR);
endmodule // spcd_sva

bind spcd_top spcd_sva u_sva (.aclk(aclk), .aresetn(aresetn), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .sck_run(sck_run), .sck_out(sck_out), .sck_oe(sck_oe),
   .sck_rise(sck_rise), .sck_fall(sck_fall), .master_mode_enable(master_mode_enable),
   .module_enable(module_enable), .irq(irq));

// *** dv/spcd_peer.sv ***
// far side serial device: drives slave select and counts serial clock rises
// assumes the select line has a pull-up, so released means high
`timescale 1ns/1ps

module spcd_peer (
   input  wire logic aclk,
   input  wire logic sel,
   input  wire logic sck,
   output logic      slave_select_n,
   output int        edges
);
   logic sck_q;
   initial begin
      slave_select_n = 1'b1;
      edges = 0;
      sck_q = 1'b0;
   end
   // select moves off the block clock edge, as a foreign master would
   always @(posedge aclk) slave_select_n <= #7 !sel;
   always @(posedge aclk) begin
      sck_q <= sck;
      if (sck && !sck_q) edges <= edges + 1;
   end
endmodule // spcd_peer

// *** dv/spcd_top_tb.sv ***
// self-checking bench: register bus tasks, event pulses and clock period checks
// assumes spcd_top with its default divider width and the peer model
`timescale 1ns/1ps
`include "spcd_defs.vh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
   $display("mismatch t=%0t got %h exp %h", $time, g, e); end end

module spcd_top_tb;
   localparam logic [11:0] A_DIV = {2'b00, `SPCD_IDX_CLOCK_DIVIDER, 2'b00};
   localparam logic [11:0] A_CS  = {2'b00, `SPCD_IDX_CONTROL_STATUS, 2'b00};
   localparam logic [11:0] A_IS  = {2'b00, `SPCD_IDX_IRQ_STATUS, 2'b00};
   localparam logic [11:0] A_IM  = {2'b00, `SPCD_IDX_IRQ_MASK, 2'b00};
   localparam logic [1:0]  OK    = `SPCD_RESP_OKAY;
   localparam logic [1:0]  SLV   = `SPCD_RESP_SLVERR;
   logic        aclk = 1'b0, aresetn = 1'b0;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic [31:0] wdata = 32'h0, rdata;
   logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, sel = 1'b0;
   logic        xfer_last_bit = 1'b0, xfer_done = 1'b0, rx_unread = 1'b0;
   logic        xfer_busy = 1'b0, write_collision = 1'b0, sck_run = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, sck_out, sck_oe, sck_rise, irq, slave_select_n;
   logic [1:0]  bresp, rresp;
   logic [7:0]  cs_bit [3] = '{8'h80, 8'h40, 8'h10};
   logic [7:0]  is_bit [3] = '{8'h01, 8'h02, 8'h08};
   logic [7:0]  divs [4] = '{8'h00, 8'h01, 8'h05, 8'hFF};
   int          edges, n, m, miscompares = 0, cmp_count = 0;

   always #12.5 aclk = ~aclk;

   spcd_top dut (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
      .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
      .slave_select_n(slave_select_n), .xfer_last_bit(xfer_last_bit), .xfer_done(xfer_done),
      .rx_unread(rx_unread), .xfer_busy(xfer_busy), .write_collision(write_collision), .sck_run(sck_run),
      .sck_out(sck_out), .sck_oe(sck_oe), .sck_rise(sck_rise), .sck_fall(), .master_mode_enable(),
      .module_enable(), .irq(irq));

   spcd_peer peer (.aclk(aclk), .sel(sel), .sck(sck_out), .slave_select_n(slave_select_n), .edges(edges));

   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic results();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
      int k;
      awaddr <= a;
      wdata <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      k = 0;
      do begin
         @(posedge aclk);
         k++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid && k < 600);
      if (k >= 600) miscompares++;
      `CHK(bresp, r)
   endtask

   task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
      int k;
      araddr <= a;
      arvalid <= 1'b1;
      k = 0;
      do begin
         @(posedge aclk);
         k++;
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid && k < 600);
      if (k >= 600) miscompares++;
      `CHK(rdata, {24'h000000, d})
      `CHK(rresp, r)
   endtask

   task automatic fire(input int k);
      case (k)
         0: xfer_done <= 1'b1;
         1: write_collision <= 1'b1;
         default: xfer_last_bit <= 1'b1;
      endcase
      @(posedge aclk);
      xfer_done <= 1'b0;
      write_collision <= 1'b0;
      xfer_last_bit <= 1'b0;
      @(posedge aclk);
   endtask

   // cycles until the next serial clock rise, as seen at the block clock
   task automatic to_rise(output int k);
      k = 0;
      do begin
         @(posedge aclk);
         k++;
      end while (!sck_rise && k < 600);
   endtask

   // ---------------------------------------------------------------
   // sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (20000) @(posedge aclk);
      miscompares++;
      results();
   end

   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(A_DIV, 8'h00, OK);
      rd(A_CS, 8'h00, OK);
      rd(A_IS, 8'h00, OK);
      rd(A_IM, 8'h00, OK);
      rd(12'h100, 8'h00, SLV);
      wr(12'h100, 8'hFF, SLV);
      $display("test reset done");
      fire(0);
      `CHK(irq, 1'b0)
      rd(A_IS, 8'h01, OK);
      wr(A_IM, 8'h0F, OK);
      `CHK(irq, 1'b1)
      wr(A_IS, 8'h01, OK);
      wr(A_CS, 8'h00, OK);
      `CHK(irq, 1'b0)
      fire(2);
      rd(A_CS, 8'h00, OK);
      rx_unread <= 1'b1;
      for (int k = 0; k < 3; k++) begin
         fire(k);
         rd(A_CS, cs_bit[k], OK);
         `CHK(irq, 1'b1)
         wr(A_CS, cs_bit[k], OK);
         rd(A_CS, cs_bit[k], OK);
         wr(A_CS, 8'h00, OK);
         rd(A_CS, 8'h00, OK);
         wr(A_IS, is_bit[k], OK);
         `CHK(irq, 1'b0)
      end
      xfer_busy <= 1'b1;
      @(posedge aclk);
      rd(A_CS, 8'h08, OK);
      xfer_busy <= 1'b0;
      $display("test flags done");
      wr(A_CS, 8'h02, OK);
      sel <= 1'b1;
      repeat (5) @(posedge aclk);
      rd(A_CS, 8'h26, OK);
      wr(A_CS, 8'h03, OK);
      rd(A_CS, 8'h27, OK);
      `CHK(irq, 1'b1)
      rd(A_IS, 8'h04, OK);
      sel <= 1'b0;
      repeat (5) @(posedge aclk);
      rd(A_CS, 8'h23, OK);
      wr(A_CS, 8'h03, OK);
      rd(A_CS, 8'h03, OK);
      wr(A_IS, 8'h04, OK);
      `CHK(irq, 1'b0)
      $display("test mode fault done");
      `CHK(sck_oe, 1'b1)
      for (int k = 0; k < 4; k++) begin
         wr(A_DIV, divs[k], OK);
         rd(A_DIV, divs[k], OK);
         sck_run <= 1'b1;
         to_rise(n);
         m = edges;
         to_rise(n);
         `CHK(n, 2 * (divs[k] + 1))
         `CHK(edges - m, 1)
         sck_run <= 1'b0;
         repeat (2) @(posedge aclk);
         `CHK(sck_out, 1'b0)
      end
      $display("test clock done");
      results();
   end
endmodule // spcd_top_tb
